// file: design/rsc_map.svh
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// clock-ratio strap codes
`define RSC_CFG_RATIO_8 2'h0
`define RSC_CFG_RATIO_32 2'h1
`define RSC_CFG_RATIO_16 2'h2
`define RSC_CFG_RESERVED 2'h3

// core-to-input multiplier values for each non-reserved strap code
`define RSC_MULT_8 6'h08
`define RSC_MULT_32 6'h20
`define RSC_MULT_16 6'h10

// pll divider value after reset
`define RSC_DIV_RESET 4'h1

// pll lock interval, in input clock cycles
`define RSC_LOCK_CYCLES 4096

// running-reset control bit position and reset value
`define RSC_RR_ENABLE_BIT 0
`define RSC_RR_CTL_RESET 1'h0

`endif

// file: design/rsc_pkg.sv
package rsc_pkg;

    typedef struct packed {
        logic [2:0] boot_cfg;
        logic [1:0] clk_cfg;
    } rsc_strap_t;

    typedef struct packed {
        logic [5:0] mult;
        logic [3:0] div;
    } rsc_pll_t;

    typedef enum logic [3:0] {
        RSC_ST_HOLD = 4'h1,
        RSC_ST_LOCK = 4'h2,
        RSC_ST_RUN = 4'h4,
        RSC_ST_RRST = 4'h8
    } rsc_state_t;

endpackage

// file: design/rsc_reset_startup_config.sv
`include "rsc_map.svh"

module rsc_reset_startup_config
    import rsc_pkg::*;
#(
    parameter int LOCK_CYCLES = `RSC_LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_reset_n,
    input wire logic sw_reset,
    input wire rsc_strap_t strap_in,
    input wire logic pm_wr,
    input wire rsc_pll_t pm_wdata,
    input wire logic rr_ctl_wr,
    input wire logic rr_ctl_wdata,
    input wire logic reset_output_pin_i,
    output logic reset_output_pin_o,
    output logic reset_output_pin_oe,
    output logic core_reset,
    output logic core_start,
    output logic pll_locked,
    output rsc_strap_t strap_captured,
    output logic cfg_reserved,
    output rsc_pll_t power_mgmt_control_reg,
    output logic running_reset_control_reg
);

    localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
    localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYCLES - 1);

    function automatic logic [5:0] ratio_mult(input logic [1:0] code);
        unique case (code)
            `RSC_CFG_RATIO_32: ratio_mult = `RSC_MULT_32;
            `RSC_CFG_RATIO_16: ratio_mult = `RSC_MULT_16;
            // reserved code falls back to the slowest ratio
            default: ratio_mult = `RSC_MULT_8;
        endcase
    endfunction

    rsc_state_t state_reg;
    rsc_state_t state_next;
    logic [CNT_W-1:0] lock_cnt_reg;
    logic hw_rel;
    logic sw_rel;
    logic hw_reset_n_reg;
    logic sw_reset_reg;
    logic running_rst_req;

    assign running_rst_req = running_reset_control_reg && !reset_output_pin_i;

    ////////////////////////////////////////////////////////////////////////////
    // release edges of the hardware and software resets

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hw_reset_n_reg <= 1'b0;
            sw_reset_reg <= 1'b0;
        end else begin
            hw_reset_n_reg <= hw_reset_n;
            sw_reset_reg <= sw_reset;
        end
    end

    assign hw_rel = hw_reset_n && !hw_reset_n_reg;
    assign sw_rel = !sw_reset && sw_reset_reg && hw_reset_n;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RSC_ST_HOLD: begin
                if (hw_reset_n) begin
                    state_next = RSC_ST_LOCK;
                end
            end
            RSC_ST_LOCK: begin
                if (lock_cnt_reg == LOCK_LAST) begin
                    state_next = RSC_ST_RUN;
                end
            end
            RSC_ST_RUN: begin
                if (sw_reset || running_rst_req) begin
                    state_next = RSC_ST_RRST;
                end
            end
            RSC_ST_RRST: begin
                // pll stays locked, so no second lock wait
                if (!sw_reset && !running_rst_req) begin
                    state_next = RSC_ST_RUN;
                end
            end
            default: state_next = RSC_ST_HOLD;
        endcase
        if (!hw_reset_n) begin
            state_next = RSC_ST_HOLD;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= RSC_ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_cnt_reg <= '0;
        end else if (state_reg == RSC_ST_LOCK) begin
            lock_cnt_reg <= lock_cnt_reg + 1'b1;
        end else begin
            lock_cnt_reg <= '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_start <= 1'b0;
            core_reset <= 1'b1;
            pll_locked <= 1'b0;
        end else begin
            core_start <= (state_next == RSC_ST_RUN) && (state_reg != RSC_ST_RUN);
            core_reset <= state_next != RSC_ST_RUN;
            pll_locked <= (state_next == RSC_ST_RUN) || (state_next == RSC_ST_RRST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap capture

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_captured <= '0;
            cfg_reserved <= 1'b0;
        end else if (hw_rel) begin
            strap_captured <= strap_in;
            cfg_reserved <= strap_in.clk_cfg == `RSC_CFG_RESERVED;
        end else if (sw_rel) begin
            // software reset re-reads only the boot mode
            strap_captured.boot_cfg <= strap_in.boot_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-management control

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_mgmt_control_reg <= '{mult: `RSC_MULT_8, div: `RSC_DIV_RESET};
        end else if (hw_rel) begin
            power_mgmt_control_reg <= '{mult: ratio_mult(strap_in.clk_cfg),
                                        div: `RSC_DIV_RESET};
        end else if (pm_wr && !core_reset) begin
            power_mgmt_control_reg <= pm_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dual-function reset pin

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            running_reset_control_reg <= `RSC_RR_CTL_RESET;
        end else if (!hw_reset_n) begin
            running_reset_control_reg <= `RSC_RR_CTL_RESET;
        end else if (rr_ctl_wr && !core_reset) begin
            running_reset_control_reg <= rr_ctl_wdata;
        end
    end

    // active-low reset out mirrors the core reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_output_pin_o <= 1'b0;
            reset_output_pin_oe <= 1'b1;
        end else begin
            reset_output_pin_o <= !core_reset;
            reset_output_pin_oe <= !running_reset_control_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic [CNT_W:0] low_run_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_run_cnt <= '0;
        end else if (!hw_reset_n || !core_reset) begin
            low_run_cnt <= '0;
        end else begin
            low_run_cnt <= low_run_cnt + 1'b1;
        end
    end

    chk_lock_wait_len: assert property (
        (core_start && $past(state_reg) == RSC_ST_LOCK) |-> low_run_cnt == (CNT_W + 1)'(LOCK_CYCLES + 1))
        else $error("core started before or after the lock interval");

    chk_ratio_from_strap: assert property (
        hw_rel |=> power_mgmt_control_reg.mult == ratio_mult($past(strap_in.clk_cfg))
            && cfg_reserved == ($past(strap_in.clk_cfg) == `RSC_CFG_RESERVED))
        else $error("start-up multiplier does not follow the ratio straps");

    chk_pm_write_run: assert property (
        (pm_wr && !core_reset && !hw_rel) |=> power_mgmt_control_reg == $past(pm_wdata))
        else $error("pll write while running was not taken");

    chk_pm_hold_reset: assert property (
        (core_reset && !hw_rel) |=> $stable(power_mgmt_control_reg))
        else $error("pll setting changed while core in reset");

    chk_pin_direction: assert property (
        ##1 reset_output_pin_oe == !$past(running_reset_control_reg))
        else $error("reset pin direction does not follow control bit");

    chk_strap_keep: assert property (
        (!hw_rel && !sw_rel) |=> $stable(strap_captured))
        else $error("captured straps changed without a reset release");

    // a new reset right after the pulse is legal, so only the pulse shape is checked
    chk_start_pulse: assert property (
        core_start |-> !core_reset ##1 !core_start)
        else $error("core start is not a single pulse into run");

endmodule // rsc_reset_startup_config

// file: bench/rsc_supervisor.sv
module rsc_supervisor
    import rsc_pkg::*;
(
    input wire logic hold,
    input wire rsc_strap_t straps,
    input wire logic pull_low,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic hw_reset_n,
    output rsc_strap_t strap_in,
    output logic pin_i,
    output logic scan_rst_n,
    output logic scan_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    // low from time zero until the bench lets go
    assign hw_reset_n = !hold;
    // bench moves straps while a reset is in force, and once in run to check the captured copy holds
    assign strap_in = straps;
    // pin has a pull-up, so released means high
    assign pin_i = pin_oe ? pin_o : !pull_low;
    // boundary-scan reset and clock held low for the whole run
    assign scan_rst_n = 1'b0;
    assign scan_clk = 1'b0;
endmodule // rsc_supervisor

// file: bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rsc_pkg::*;
    localparam int LCK = 8;
    logic clk = 0, rst = 1, hold = 1, sw_reset = 0, pull_low = 0;
    logic pm_wr = 0, rr_ctl_wr = 0, rr_ctl_wdata = 0, hw_reset_n, pin_i, pin_o, pin_oe;
    logic core_reset, core_start, pll_locked, cfg_reserved, rr_reg;
    rsc_strap_t straps = '0, strap_in, strap_captured;
    rsc_pll_t pm_wdata = '0, pm_reg;
    logic [5:0] mt [4] = '{6'h08, 6'h20, 6'h10, 6'h08};
    int mismatches = 0, n_compared = 0;
    // free-running, never stopped
    always #5 clk = ~clk;
    rsc_supervisor u_far (.hold(hold), .straps(straps), .pull_low(pull_low), .pin_o(pin_o),
        .pin_oe(pin_oe), .hw_reset_n(hw_reset_n), .strap_in(strap_in), .pin_i(pin_i),
        .scan_rst_n(), .scan_clk());
    rsc_reset_startup_config #(.LOCK_CYCLES(LCK)) u_dut (.clk(clk), .rst(rst),
        .hw_reset_n(hw_reset_n), .sw_reset(sw_reset), .strap_in(strap_in), .pm_wr(pm_wr),
        .pm_wdata(pm_wdata), .rr_ctl_wr(rr_ctl_wr), .rr_ctl_wdata(rr_ctl_wdata),
        .reset_output_pin_i(pin_i), .reset_output_pin_o(pin_o),
        .reset_output_pin_oe(pin_oe), .core_reset(core_reset), .core_start(core_start),
        .pll_locked(pll_locked), .strap_captured(strap_captured),
        .cfg_reserved(cfg_reserved), .power_mgmt_control_reg(pm_reg),
        .running_reset_control_reg(rr_reg));
    task automatic test_done();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // counts edges from the launching edge to the start pulse
    task automatic wait_start(output int n);
        n = 0;
        while (core_start !== 1'b1) begin
            tick(1);
            n++;
            if (n > 40) begin
                mismatches++;
                $display("FAIL %0t no start", $time);
                test_done();
            end
        end
    endtask
    task automatic wr(input logic pm, input logic rr, input logic rv, input rsc_pll_t v);
        @(posedge clk);
        pm_wr <= pm;
        rr_ctl_wr <= rr;
        rr_ctl_wdata <= rv;
        pm_wdata <= v;
        @(posedge clk);
        pm_wr <= 1'b0;
        rr_ctl_wr <= 1'b0;
        tick(1);
    endtask
    task automatic t_boot(input rsc_strap_t s, input logic [5:0] m);
        int n;
        @(posedge clk);
        hold <= 1'b1;
        straps <= s;
        tick(3);
        chk(10'({core_reset, pll_locked, pin_o}), 10'h004, "held");
        @(posedge clk);
        hold <= 1'b0;
        wait_start(n);
        chk(10'(n >= LCK + 1 && n <= LCK + 2), 10'h001, "lock wait");
        chk(10'({core_reset, pll_locked}), 10'h001, "run");
        chk(pm_reg, {m, 4'h1}, "ratio");
        chk(10'(cfg_reserved), 10'(s.clk_cfg == 2'h3), "resv");
        chk(10'({rr_reg, pin_oe}), 10'h001, "pin dflt");
        @(posedge clk);
        straps <= ~s;
        tick(2);
        chk(10'(core_start), 10'h000, "pulse");
        chk(10'(pin_o), 10'h001, "rst out");
        chk(10'(strap_captured), 10'(s), "kept");
    endtask
    task automatic t_pm();
        wr(1'b1, 1'b0, 1'b0, {6'h0C, 4'h3});
        chk(pm_reg, {6'h0C, 4'h3}, "pm wr");
    endtask
    task automatic t_sw();
        int n;
        rsc_strap_t old;
        old = strap_captured;
        @(posedge clk);
        sw_reset <= 1'b1;
        straps <= {3'h5, ~old.clk_cfg};
        tick(2);
        chk(10'(core_reset), 10'h001, "sw rst");
        // writes must be refused while the core is held
        wr(1'b1, 1'b1, 1'b1, {6'h3F, 4'hF});
        @(posedge clk);
        sw_reset <= 1'b0;
        wait_start(n);
        chk(10'(n <= 2), 10'h001, "no lock");
        chk(pm_reg, {6'h0C, 4'h3}, "pm hold");
        chk(10'(rr_reg), 10'h000, "rr hold");
        chk(10'(strap_captured), 10'({3'h5, old.clk_cfg}), "boot");
    endtask
    task automatic t_rr();
        int n;
        wr(1'b0, 1'b1, 1'b1, '0);
        chk(10'({rr_reg, pin_oe}), 10'h002, "rr on");
        @(posedge clk);
        pull_low <= 1'b1;
        tick(2);
        chk(10'(core_reset), 10'h001, "rr in");
        @(posedge clk);
        pull_low <= 1'b0;
        wait_start(n);
        chk(10'(n <= 2), 10'h001, "rr out");
        wr(1'b0, 1'b1, 1'b0, '0);
        chk(10'({rr_reg, pin_oe}), 10'h001, "rr off");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            t_boot({3'(i + 1), 2'(i)}, mt[i]);
        end
        t_pm();
        t_sw();
        t_rr();
        test_done();
    end
endmodule // tb
